// ==== core/psc_pkg.sv ====
// Constants shared by the synthesizer serial control logic.
// Assumes a single 10 MHz system clock with every pin sampled on it.
package psc_pkg;

	// ------------------------------------------------------------
	// Clock and widths
	// ------------------------------------------------------------
	localparam int unsigned PSC_CLK_PERIOD_NS = 100;
	localparam int unsigned PSC_FREQ_W = 20;
	localparam int unsigned PSC_ENH_W = 8;
	localparam int unsigned PSC_R_W = 6;
	localparam int unsigned PSC_M_W = 9;
	localparam int unsigned PSC_A_W = 4;

	// ------------------------------------------------------------
	// Frequency word layout, field bits listed from MSB down
	// ------------------------------------------------------------
	localparam int unsigned PSC_R_POS [PSC_R_W] = '{0, 1, 12, 13, 14, 15};
	localparam int unsigned PSC_M_POS [PSC_M_W] = '{2, 3, 5, 6, 7, 8, 9, 10, 11};
	localparam int unsigned PSC_A_POS [PSC_A_W] = '{16, 17, 18, 19};
	localparam int unsigned PSC_BYPASS_POS = 4;

	// ------------------------------------------------------------
	// Test mode control bits
	// ------------------------------------------------------------
	localparam int unsigned PSC_ENH_READBACK = 1;
	localparam int unsigned PSC_ENH_MAIN_OUT = 2;
	localparam int unsigned PSC_ENH_POWER_DOWN = 3;
	localparam int unsigned PSC_ENH_COUNTER_LOAD = 4;
	localparam int unsigned PSC_ENH_MODSEL_OUT = 5;
	localparam int unsigned PSC_ENH_COMP_OUT = 6;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [PSC_FREQ_W-1:0] PSC_FREQ_RST = 20'h00000;
	localparam logic [PSC_ENH_W-1:0] PSC_ENH_RST = 8'h00;
	localparam logic [PSC_R_W-1:0] PSC_R_ZERO = 6'h00;

	// Source of the counter setting
	typedef enum logic [2:0] {
		PSC_SRC_PRIMARY = 3'h1,
		PSC_SRC_SECONDARY = 3'h2,
		PSC_SRC_NONVOL = 3'h4
	} psc_src_type;

endpackage

// ==== core/psc_control.sv ====
// Serial programming, register selection, reference divider and phase
// detector of an integer-N synthesizer.
// Assumes all pins are synchronous to ref_clk_i and held at least one
// clock per level; the serial clock pin is sampled, not used as a clock.
//
// Summary of operation
// RULE1 - Six-bit reference divider divides reference input by programmed value plus one.
// RULE2 - Reference value zero passes reference input straight to the phase detector.
// RULE3 - Detector acts on rising edges; main clock leading pulses down output low.
// RULE4 - Reference leading pulses the active-low up output instead.
// RULE5 - Pulse length follows the phase difference between the two divided clocks.
// RULE6 - Up pulse drives pump source, down pulse drives pump sink.
// RULE7 - Integration node is NAND of up and down; lock output is their AND.
// RULE8 - Serial data sampled on rising serial clock, least significant bit first.
// RULE9 - Strobe lines pick primary, test mode or nonvolatile register as destination.
// RULE10 - Three 20-bit frequency words supply reference, main, swallow values and bypass.
// RULE11 - Word bits map reference, main, bypass and swallow fields in fixed order.
// RULE12 - Primary word is unbuffered; its shifting contents reach counters continuously.
// RULE13 - Secondary word copies primary word on rising secondary write strobe.
// RULE14 - Select lines choose primary, secondary or nonvolatile word for the counters.
// RULE15 - Nonvolatile word loads from store on select rise or load-line fall.
// RULE16 - Counters only ever see store data through the nonvolatile word.
// RULE17 - Readback mode shifts nonvolatile word out LSB first, refilling from data in.
// RULE18 - Test mode word shifts into holding stage, applied on test write falling edge.
// RULE19 - Test functions act only with their bit high and enable line low.
// RULE20 - Host keeps enable line high until test mode word is known.
// RULE21 - Bits 2, 5, 6 route main, modulus select, reference output to data out.
// RULE22 - Bit 3 powers down, bit 4 loads counters continuously; reserved bits zero.
// RULE23 - Bypass bit powers down prescaler and swallow counter.
`timescale 1ns/1ns
`default_nettype none

module psc_control (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic ser_clk_i,
	input wire logic ser_data_i,
	input wire logic secondary_write_i,
	input wire logic test_mode_write_i,
	input wire logic nonvolatile_load_line_i,
	input wire logic nonvolatile_select_line_i,
	input wire logic frequency_source_select_i,
	input wire logic test_mode_enable_n_i,
	input wire logic [psc_pkg::PSC_FREQ_W-1:0] nv_store_data_i,
	input wire logic ref_in_i,
	input wire logic main_div_i,
	input wire logic modulus_select_i,
	output logic comp_clk_o,
	output logic phase_up_pulse_n_o,
	output logic phase_down_pulse_n_o,
	output logic pump_source_o,
	output logic pump_sink_o,
	output logic lock_integration_node_o,
	output logic lock_indicator_o,
	output logic data_out_o,
	output logic [psc_pkg::PSC_R_W-1:0] ref_count_o,
	output logic [psc_pkg::PSC_M_W-1:0] main_count_o,
	output logic [psc_pkg::PSC_A_W-1:0] swallow_count_o,
	output logic prescaler_bypass_bit_o,
	output logic prescaler_power_down_o,
	output logic power_down_o
);

	// ------------------------------------------------------------
	// Edge detection on sampled pins
	// ------------------------------------------------------------
	logic ser_clk_prev_q, swr_prev_q, ewr_prev_q, nvl_prev_q;
	logic nvs_prev_q, ref_prev_q, main_prev_q, ser_rise, swr_rise;
	logic ewr_fall, store_load, ref_rise, main_rise;

	// Previous pin levels, one flop each
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ser_clk_prev_q <= 1'b0;
			swr_prev_q <= 1'b0;
			ewr_prev_q <= 1'b0;
			nvl_prev_q <= 1'b0;
			nvs_prev_q <= 1'b0;
			ref_prev_q <= 1'b0;
			main_prev_q <= 1'b0;
		end else if (ce_i) begin
			ser_clk_prev_q <= ser_clk_i;
			swr_prev_q <= secondary_write_i;
			ewr_prev_q <= test_mode_write_i;
			nvl_prev_q <= nonvolatile_load_line_i;
			nvs_prev_q <= nonvolatile_select_line_i;
			ref_prev_q <= ref_in_i;
			main_prev_q <= main_div_i;
		end
	end

	// Edge strobes used by the register and detector logic
	assign ser_rise = ser_clk_i & ~ser_clk_prev_q; // RULE8
	assign swr_rise = secondary_write_i & ~swr_prev_q;
	assign ewr_fall = ~test_mode_write_i & ewr_prev_q;
	assign store_load = (nonvolatile_select_line_i & ~nvs_prev_q & ~nonvolatile_load_line_i)
		| (~nonvolatile_load_line_i & nvl_prev_q & nonvolatile_select_line_i); // RULE15
	assign ref_rise = ref_in_i & ~ref_prev_q;
	assign main_rise = main_div_i & ~main_prev_q;

	// ------------------------------------------------------------
	// Serial registers
	// ------------------------------------------------------------
	logic [psc_pkg::PSC_FREQ_W-1:0] primary_q, secondary_q, nv_shift_q, nv_ctrl_q;
	logic [psc_pkg::PSC_ENH_W-1:0] enh_hold_q, enh_q, enh_eff;
	logic readback_en;

	// Test functions gated by the active-low enable line
	assign enh_eff = enh_q & {psc_pkg::PSC_ENH_W{~test_mode_enable_n_i}}; // RULE19 RULE20
	assign readback_en = enh_eff[psc_pkg::PSC_ENH_READBACK];

	// Primary word shifts in LSB first while both strobes and load are low
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			primary_q <= psc_pkg::PSC_FREQ_RST;
		end else if (ce_i && ser_rise && !nonvolatile_load_line_i && !test_mode_write_i
			&& !secondary_write_i) begin // RULE9
			primary_q <= {ser_data_i, primary_q[psc_pkg::PSC_FREQ_W-1:1]}; // RULE8
		end
	end

	// Secondary word is a parallel copy of the primary word
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			secondary_q <= psc_pkg::PSC_FREQ_RST;
		end else if (ce_i && swr_rise) begin
			secondary_q <= primary_q; // RULE13
		end
	end

	// Nonvolatile shift image: store load wins over a coincident shift
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			nv_shift_q <= psc_pkg::PSC_FREQ_RST;
		end else if (ce_i) begin
			if (store_load) begin
				nv_shift_q <= nv_store_data_i; // RULE15
			end else if (ser_rise && (nonvolatile_load_line_i || readback_en)) begin
				nv_shift_q <= {ser_data_i, nv_shift_q[psc_pkg::PSC_FREQ_W-1:1]}; // RULE9 RULE17
			end
		end
	end

	// Counter-facing copy only ever takes store data, never shifted bits
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			nv_ctrl_q <= psc_pkg::PSC_FREQ_RST;
		end else if (ce_i && store_load) begin
			nv_ctrl_q <= nv_store_data_i; // RULE16
		end
	end

	// Test mode holding stage; the strobe high selects it
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			enh_hold_q <= psc_pkg::PSC_ENH_RST;
		end else if (ce_i && ser_rise && test_mode_write_i && !nonvolatile_load_line_i) begin
			enh_hold_q <= {ser_data_i, enh_hold_q[psc_pkg::PSC_ENH_W-1:1]}; // RULE9
		end
	end

	// Buffered so partially shifted bits never reach the synthesizer
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			enh_q <= psc_pkg::PSC_ENH_RST;
		end else if (ce_i && ewr_fall) begin
			enh_q <= enh_hold_q; // RULE18
		end
	end

	// ------------------------------------------------------------
	// Source selection and counter setting
	// ------------------------------------------------------------
	psc_pkg::psc_src_type src_q;
	logic [psc_pkg::PSC_FREQ_W-1:0] sel_word, act_q;
	logic [psc_pkg::PSC_R_W-1:0] sel_r, ref_cnt_q, ref_cnt_d;
	logic pwr_dn, cont_load;

	// Source held while the load line is high
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			src_q <= psc_pkg::PSC_SRC_SECONDARY;
		end else if (ce_i && !nonvolatile_load_line_i) begin
			if (nonvolatile_select_line_i) begin
				src_q <= psc_pkg::PSC_SRC_NONVOL; // RULE14
			end else if (frequency_source_select_i) begin
				src_q <= psc_pkg::PSC_SRC_PRIMARY;
			end else begin
				src_q <= psc_pkg::PSC_SRC_SECONDARY;
			end
		end
	end

	// Word of the chosen source
	always_comb begin
		case (src_q)
			psc_pkg::PSC_SRC_PRIMARY: sel_word = primary_q; // RULE12
			psc_pkg::PSC_SRC_NONVOL: sel_word = nv_ctrl_q; // RULE16
			default: sel_word = secondary_q;
		endcase
	end

	assign pwr_dn = enh_eff[psc_pkg::PSC_ENH_POWER_DOWN];
	// Primary and counter-load mode bypass the cycle boundary update
	assign cont_load = enh_eff[psc_pkg::PSC_ENH_COUNTER_LOAD] // RULE22
		| (src_q == psc_pkg::PSC_SRC_PRIMARY); // RULE12

	// Setting otherwise updates at a comparison period boundary to avoid glitches
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			act_q <= psc_pkg::PSC_FREQ_RST;
		end else if (ce_i && (cont_load || (ref_rise && ref_cnt_d == psc_pkg::PSC_R_ZERO))) begin
			act_q <= sel_word;
		end
	end

	// Field unpacking of the applied word
	genvar gi;
	generate
		for (gi = 0; gi < psc_pkg::PSC_R_W; gi++) begin : g_r
			assign ref_count_o[psc_pkg::PSC_R_W-1-gi] = act_q[psc_pkg::PSC_R_POS[gi]]; // RULE11
		end
		for (gi = 0; gi < psc_pkg::PSC_M_W; gi++) begin : g_m
			assign main_count_o[psc_pkg::PSC_M_W-1-gi] = act_q[psc_pkg::PSC_M_POS[gi]]; // RULE10
		end
		for (gi = 0; gi < psc_pkg::PSC_A_W; gi++) begin : g_a
			assign swallow_count_o[psc_pkg::PSC_A_W-1-gi] = act_q[psc_pkg::PSC_A_POS[gi]];
		end
	endgenerate
	assign prescaler_bypass_bit_o = act_q[psc_pkg::PSC_BYPASS_POS];
	assign sel_r = ref_count_o;

	// Power state flops
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			power_down_o <= 1'b0;
			prescaler_power_down_o <= 1'b0;
		end else if (ce_i) begin
			power_down_o <= pwr_dn; // RULE22
			prescaler_power_down_o <= pwr_dn | sel_word[psc_pkg::PSC_BYPASS_POS]; // RULE23
		end
	end

	// ------------------------------------------------------------
	// Reference divider
	// ------------------------------------------------------------
	// Wrap at the programmed value; zero keeps the count at zero
	always_comb begin
		ref_cnt_d = ref_cnt_q;
		if (ref_rise) begin
			if (ref_cnt_q >= sel_r) begin
				ref_cnt_d = psc_pkg::PSC_R_ZERO; // RULE1
			end else begin
				ref_cnt_d = ref_cnt_q + 6'h01;
			end
		end
	end

	// Output is the reference gated to the zero-count period
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ref_cnt_q <= psc_pkg::PSC_R_ZERO;
			comp_clk_o <= 1'b0;
		end else if (ce_i && !pwr_dn) begin
			ref_cnt_q <= ref_cnt_d;
			comp_clk_o <= ref_in_i & (ref_cnt_d == psc_pkg::PSC_R_ZERO); // RULE1 RULE2
		end
	end

	// ------------------------------------------------------------
	// Phase detector and lock logic
	// ------------------------------------------------------------
	logic comp_rise, up_q, dn_q, up_d, dn_d;
	assign comp_rise = ref_in_i & ~ref_prev_q & (ref_cnt_d == psc_pkg::PSC_R_ZERO);

	// Set on own edge, both cleared once both have arrived or in power down
	always_comb begin
		up_d = up_q | comp_rise; // RULE4
		dn_d = dn_q | main_rise; // RULE3
		if ((up_d && dn_d) || pwr_dn) begin // RULE22
			up_d = 1'b0; // RULE5
			dn_d = 1'b0;
		end
	end

	// Outputs registered from the next detector state
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			up_q <= 1'b0;
			dn_q <= 1'b0;
			phase_up_pulse_n_o <= 1'b1;
			phase_down_pulse_n_o <= 1'b1;
			pump_source_o <= 1'b0;
			pump_sink_o <= 1'b0;
			lock_integration_node_o <= 1'b0;
			lock_indicator_o <= 1'b1;
		end else if (ce_i) begin
			up_q <= up_d;
			dn_q <= dn_d;
			phase_up_pulse_n_o <= ~up_d; // RULE4
			phase_down_pulse_n_o <= ~dn_d; // RULE3
			pump_source_o <= up_d; // RULE6
			pump_sink_o <= dn_d; // RULE6
			lock_integration_node_o <= up_d | dn_d; // RULE7
			lock_indicator_o <= ~(up_d | dn_d); // RULE7
		end
	end

	// ------------------------------------------------------------
	// Data out multiplexer
	// ------------------------------------------------------------
	// Only one routing bit is expected at a time; lowest bit wins otherwise
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_out_o <= 1'b0;
		end else if (ce_i) begin
			if (readback_en) begin
				data_out_o <= nv_shift_q[0]; // RULE17
			end else if (enh_eff[psc_pkg::PSC_ENH_MAIN_OUT]) begin
				data_out_o <= main_div_i; // RULE21
			end else if (enh_eff[psc_pkg::PSC_ENH_MODSEL_OUT]) begin
				data_out_o <= modulus_select_i; // RULE21
			end else if (enh_eff[psc_pkg::PSC_ENH_COMP_OUT]) begin
				data_out_o <= comp_clk_o; // RULE21
			end else begin
				data_out_o <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i || !ce_i);

	sequence s_readback_shift;
		ser_rise && readback_en && !store_load;
	endsequence

	a_ref_passthru: assert property (ref_rise && sel_r == psc_pkg::PSC_R_ZERO && !pwr_dn // RULE2
		|=> comp_clk_o) else $error("reference not passed through at zero");
	a_ref_wrap: assert property (ref_rise && ref_cnt_q == sel_r && !pwr_dn // RULE1
		|=> ref_cnt_q == psc_pkg::PSC_R_ZERO) else $error("reference divider did not wrap");
	a_down_lead: assert property (main_rise && !comp_rise && !up_q && !pwr_dn // RULE3
		|=> !phase_down_pulse_n_o && phase_up_pulse_n_o) else $error("down pulse missing");
	a_up_lead: assert property (comp_rise && !main_rise && !dn_q && !pwr_dn // RULE4
		|=> !phase_up_pulse_n_o && phase_down_pulse_n_o) else $error("up pulse missing");
	a_pump_map: assert property (pump_source_o == !phase_up_pulse_n_o // RULE6
		&& pump_sink_o == !phase_down_pulse_n_o) else $error("pump not following detector");
	a_lock_logic: assert property (lock_indicator_o == (phase_up_pulse_n_o // RULE7
		&& phase_down_pulse_n_o) && lock_integration_node_o == !lock_indicator_o)
		else $error("lock outputs inconsistent");
	a_sec_capture: assert property (swr_rise // RULE13
		|=> secondary_q == $past(primary_q)) else $error("secondary copy wrong");
	a_enh_buffer: assert property (!ewr_fall |=> $stable(enh_q)) // RULE18
		else $error("test mode word changed without strobe");
	a_nv_store: assert property (store_load // RULE15
		|=> nv_ctrl_q == $past(nv_store_data_i) && nv_shift_q == nv_ctrl_q)
		else $error("store load not captured");
	a_nv_isolate: assert property (!store_load |=> $stable(nv_ctrl_q)) // RULE16
		else $error("counter copy changed without store load");
	a_readback: assert property (s_readback_shift // RULE17
		|=> nv_shift_q[psc_pkg::PSC_FREQ_W-1] == $past(ser_data_i) ##1 !$past(readback_en)
		|| data_out_o == $past(nv_shift_q[0])) else $error("readback shift wrong");

endmodule

`default_nettype wire

// ==== tb/psc_host_model.sv ====
// Host side model: drives the serial clock, data and strobe lines.
// Assumes the bench calls its tasks from one process tied to ref_clk_i.
`timescale 1ns/1ns
`default_nettype none

module psc_host_model (
	input wire logic ref_clk_i,
	output logic ser_clk_o,
	output logic ser_data_o,
	output logic secondary_write_o,
	output logic test_mode_write_o,
	output logic nonvolatile_load_line_o
);
	// --------------------------------------------------------
	// Idle levels at time zero
	// --------------------------------------------------------
	initial begin
		ser_clk_o = 1'b0;
		ser_data_o = 1'b0;
		secondary_write_o = 1'b0;
		test_mode_write_o = 1'b0;
		nonvolatile_load_line_o = 1'b0;
	end

	// One bit: data a cycle ahead, clock high for one cycle
	task automatic send_bit(input logic b);
		@(posedge ref_clk_i) #10;
		ser_data_o = b;
		@(posedge ref_clk_i) #10;
		ser_clk_o = 1'b1;
		@(posedge ref_clk_i) #10;
		ser_clk_o = 1'b0;
		ser_data_o = ~b; // Inverted afterwards, so a stale bit cannot pass
	endtask

	// Strobes set while the clock is low, then n bits LSB first
	task automatic send_word(input logic [19:0] w, input int n, input logic tw, input logic ld);
		@(posedge ref_clk_i) #10;
		test_mode_write_o = tw;
		nonvolatile_load_line_o = ld;
		for (int i = 0; i < n; i++) send_bit(w[i]);
	endtask

	// Copy strobe, high for two cycles
	task automatic sec_pulse();
		@(posedge ref_clk_i) #10;
		secondary_write_o = 1'b1;
		@(posedge ref_clk_i) #10;
		@(posedge ref_clk_i) #10;
		secondary_write_o = 1'b0;
	endtask
endmodule

`default_nettype wire

// ==== tb/test_pll_serial_control_logic.sv ====
// Self-checking bench for the synthesizer serial control logic.
// Assumes a 10 MHz clock; every input moves 10 ns after a rising edge.
`timescale 1ns/1ns
`default_nettype none

module test_pll_serial_control_logic;
	localparam logic [19:0] W1 = 20'hA5C3E, W2 = 20'h5A6D0, W3 = 20'h12340;
	localparam logic [19:0] D1 = 20'h6B1C9, D2 = 20'h39E57, P1 = 20'hC4A2D, P2 = 20'h8F1B6;
	localparam logic [19:0] RW [3] = '{20'h0F003, 20'h0C000, 20'h00000};
	localparam int RN [3] = '{63, 3, 0};
	localparam logic [7:0] RT [3] = '{8'h04, 8'h20, 8'h40};
	logic ref_clk, ser_clk, ser_data, sec_wr, tm_wr, ld, comp, up_n, dn_n, src, snk;
	logic node, lock, dout, ppd, pdn, pb, comp_prev = 1'b0;
	logic rst_n = 1'b0, sel = 1'b0, frequency_source_select = 1'b1, enh_n = 1'b1;
	logic ref_in = 1'b0, main_div = 1'b0, modsel = 1'b0;
	logic [19:0] store = 20'h00000;
	logic [5:0] r_cnt;
	logic [8:0] m_cnt;
	logic [3:0] a_cnt;
	int errors = 0, num_checks = 0, comp_n = 0, up_len = 0, dn_len = 0, i;
	wire logic [19:0] flds = {r_cnt, m_cnt, a_cnt, pb};

	psc_host_model host_u (.ref_clk_i(ref_clk), .ser_clk_o(ser_clk), .ser_data_o(ser_data),
		.secondary_write_o(sec_wr), .test_mode_write_o(tm_wr), .nonvolatile_load_line_o(ld));

	psc_control dut_u (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .ce_i(1'b1), .ser_clk_i(ser_clk),
		.ser_data_i(ser_data), .secondary_write_i(sec_wr), .test_mode_write_i(tm_wr),
		.nonvolatile_load_line_i(ld), .nonvolatile_select_line_i(sel),
		.frequency_source_select_i(frequency_source_select), .test_mode_enable_n_i(enh_n),
		.nv_store_data_i(store), .ref_in_i(ref_in), .main_div_i(main_div),
		.modulus_select_i(modsel), .comp_clk_o(comp), .phase_up_pulse_n_o(up_n),
		.phase_down_pulse_n_o(dn_n), .pump_source_o(src), .pump_sink_o(snk),
		.lock_integration_node_o(node), .lock_indicator_o(lock), .data_out_o(dout),
		.ref_count_o(r_cnt), .main_count_o(m_cnt), .swallow_count_o(a_cnt),
		.prescaler_bypass_bit_o(pb), .prescaler_power_down_o(ppd), .power_down_o(pdn));

	// --------------------------------------------------------
	// Clock, edge and pulse counters
	// --------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// Counted on edges, so widths are in whole cycles
	always @(posedge ref_clk) begin
		if (comp === 1'b1 && comp_prev === 1'b0) comp_n++;
		comp_prev = comp;
		if (up_n === 1'b0) up_len++;
		if (dn_n === 1'b0) dn_len++;
	end

	// --------------------------------------------------------
	// Helpers
	// --------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#10;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t ns: %s got %0h expected %0h", $time, msg, got, exp);
		end
	endtask

	// Word bits regrouped as {R, M, A, bypass}
	function automatic logic [19:0] fld(input logic [19:0] w);
		fld = {w[0], w[1], w[12], w[13], w[14], w[15], w[2], w[3], w[5], w[6], w[7], w[8],
			w[9], w[10], w[11], w[16], w[17], w[18], w[19], w[4]};
	endfunction

	task automatic ref_pulses(input int n);
		repeat (n) begin
			ref_in = 1'b1;
			tick(3);
			ref_in = 1'b0;
			tick(3);
		end
	endtask

	// Holding stage fill, then the strobe fall applies it
	task automatic tmode(input logic [7:0] v);
		host_u.send_word({12'h000, v}, 8, 1'b1, 1'b0);
		host_u.send_word(20'h00000, 0, 1'b0, 1'b0);
	endtask

	// One edge leads by k cycles, then both settle high
	task automatic phase(input logic lead_ref, input int k);
		up_len = 0;
		dn_len = 0;
		if (lead_ref) ref_in = 1'b1;
		else main_div = 1'b1;
		tick(k);
		check({src, snk, node, lock}, lead_ref ? 4'hA : 4'h6, "pulse");
		ref_in = 1'b1;
		main_div = 1'b1;
		tick(4);
		{ref_in, main_div} = 2'b00;
		tick(4);
		check(lead_ref ? up_len : dn_len, k, "pulse width");
		check(lead_ref ? dn_len : up_len, 0, "other pulse");
		check({up_n, dn_n, node, lock}, 4'hD, "idle");
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// Generous bound, runs normally take under 5000 cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		give_verdict();
	end

	// --------------------------------------------------------
	// Test sequence
	// --------------------------------------------------------
	initial begin
		repeat (12) @(posedge ref_clk);
		#10 rst_n = 1'b1;
		tick(2);
		check({up_n, dn_n, node, lock, dout, pdn}, 6'h34, "reset pins");
		check(flds, 20'h00000, "reset counts");
		for (i = 0; i < 4; i++) phase(i[0], 3 + 3 * i[1]);
		$display("test detector done");
		host_u.send_word(W1, 20, 1'b0, 1'b0);
		tick(3);
		check(flds, fld(W1), "primary");
		host_u.send_word(W2, 10, 1'b0, 1'b0);
		tick(3);
		check(flds, fld((W1 >> 10) | (W2 << 10)), "partial");
		host_u.send_word(W2 >> 10, 10, 1'b0, 1'b0);
		host_u.sec_pulse();
		host_u.send_word(W3, 20, 1'b0, 1'b0);
		tick(3);
		check({flds, ppd}, {fld(W3), 1'b0}, "primary again");
		frequency_source_select = 1'b0;
		ref_pulses(16);
		check({flds, ppd}, {fld(W2), 1'b1}, "secondary");
		$display("test registers done");
		frequency_source_select = 1'b1;
		for (i = 0; i < 3; i++) begin
			host_u.send_word(RW[i], 20, 1'b0, 1'b0);
			ref_pulses(RN[i] + 2);
			comp_n = 0;
			ref_pulses(2 * (RN[i] + 1));
			check(comp_n, 2, "divide");
		end
		$display("test divider done");
		// Enable kept high until a known word is applied
		tmode(8'h00);
		enh_n = 1'b0;
		host_u.send_word(20'h00008, 8, 1'b1, 1'b0);
		tick(3);
		check(pdn, 1'b0, "holding stage");
		host_u.send_word(20'h00000, 0, 1'b0, 1'b0);
		tick(3);
		check({pdn, ppd, up_n, dn_n}, 4'hF, "power down");
		enh_n = 1'b1;
		tick(3);
		check(pdn, 1'b0, "enable off");
		enh_n = 1'b0;
		// One routing bit at a time, reserved bits zero; reference output runs at R zero
		for (i = 0; i < 3; i++) begin
			tmode(RT[i]);
			{main_div, modsel, ref_in} = 3'b100 >> i;
			tick(4);
			check(dout, 1'b1, "route high");
			{main_div, modsel, ref_in} = ~(3'b100 >> i);
			tick(4);
			check(dout, 1'b0, "route low");
			{main_div, modsel, ref_in} = 3'b000;
		end
		$display("test test mode done");
		tmode(8'h12);
		host_u.send_word(D1, 20, 1'b0, 1'b1);
		host_u.send_word(20'h00000, 0, 1'b0, 1'b0);
		store = P1;
		tick(2);
		sel = 1'b1;
		tick(3);
		check({flds, dout}, {fld(P1), P1[0]}, "load on select");
		host_u.send_word(20'h00000, 0, 1'b0, 1'b1);
		store = P2;
		for (i = 0; i < 20; i++) begin
			host_u.send_bit(D2[i]);
			tick(1);
			check(dout, i < 19 ? P1[i + 1] : D2[0], "readback");
		end
		check(flds, fld(P1), "serial kept off");
		host_u.send_word(20'h00000, 0, 1'b0, 1'b0);
		tick(3);
		check({flds, dout}, {fld(P2), P2[0]}, "load on fall");
		$display("test nonvolatile done");
		give_verdict();
	end
endmodule

`default_nettype wire
